/* File: design/pia_core.sv */
// platform interrupt arbiter top: gateways, two contexts, claim and complete
//
// Overview of operation
// - at most thirty-two sources, addressed by id
// - source zero never pends, means no interrupt
// - separate machine and supervisor request outputs
// - sources are level sensitive, active high, held
// - asserted source request sets its waiting flag
// - only waiting sources compete with their priority
// - per output allow flag gates competition
// - larger priority wins, id travels with it
// - equal priority goes to the lower id
// - request asserted only when priority exceeds threshold
// - claim read returns the id of the highest priority waiting source
// - claim with nothing waiting returns zero
// - claim clears the returned source's waiting flag
// - claimed source stays quiet until completion
// - completion write of the id re-arms the gateway
`timescale 1ns/1ps
`default_nettype none
module pia_core
  import pia_pkg::*;
#(
  parameter int unsigned NSRC   = PIA_NSRC,   // number of ids incl. zero
  parameter int unsigned PRIO_W = PIA_PRIO_W  // priority field width
) (
  input  wire logic                        core_clk,       // 250 MHz clock
  input  wire logic                        rstn,           // async, low
  input  wire logic [NSRC-1:0]             src_req,        // source levels
  input  wire logic [NSRC-1:0][PRIO_W-1:0] src_priority,   // per source
  input  wire pia_ctx_cfg_t                m_cfg,          // machine config
  input  wire pia_ctx_cfg_t                s_cfg,          // supervisor cfg
  input  wire pia_access_t                 m_acc,          // machine access
  input  wire pia_access_t                 s_acc,          // supervisor acc
  output logic [PIA_ID_W-1:0]              m_claim_id,     // machine claim
  output logic [PIA_ID_W-1:0]              s_claim_id,     // supervisor
  output logic                             hart_external_request_m, // mach
  output logic                             hart_external_request_s, // sup
  output logic [NSRC-1:0]                  source_waiting_flag,     // state
  output logic [NSRC-1:0]                  source_in_service        // state
);
  // refuse sizes the id field or the scan cannot serve; the threshold
  // field of the config carrier is only the package priority width wide
  if (NSRC > PIA_MAX_SRC || NSRC < 2 || PRIO_W < 1 ||
      PRIO_W > PIA_PRIO_W) begin : g_bad
    $error("pia_core: NSRC must be 2..32 and PRIO_W 1..3");
  end

  logic [NSRC-1:0]     pending;     // source_waiting_flag storage
  logic [NSRC-1:0]     in_service;  // claimed, waiting for completion
  logic [PIA_ID_W-1:0] m_win_id;    // machine context winner
  logic [PIA_ID_W-1:0] s_win_id;    // supervisor context winner
  logic [PRIO_W-1:0]   m_win_prio;  // machine winning priority
  logic [PRIO_W-1:0]   s_win_prio;  // supervisor winning priority

  assign source_waiting_flag = pending;
  assign source_in_service   = in_service;

  // machine context priority scan
  pia_arbiter #(.NSRC(NSRC), .PRIO_W(PRIO_W)) u_arb_m (
    .pending  (pending),
    .allow    (m_cfg.allow[NSRC-1:0]),
    .prio     (src_priority),
    .win_id   (m_win_id),
    .win_prio (m_win_prio)
  );

  // supervisor context priority scan
  pia_arbiter #(.NSRC(NSRC), .PRIO_W(PRIO_W)) u_arb_s (
    .pending  (pending),
    .allow    (s_cfg.allow[NSRC-1:0]),
    .prio     (src_priority),
    .win_id   (s_win_id),
    .win_prio (s_win_prio)
  );

  // threshold compare; the threshold field is narrowed to the priority width
  wire m_over = m_win_prio > m_cfg.threshold[PRIO_W-1:0];
  wire s_over = s_win_prio > s_cfg.threshold[PRIO_W-1:0];

  // a claim only takes effect for a real winner
  wire m_claim_hit = m_acc.claim_rd && (m_win_id != PIA_NO_IRQ);
  wire s_claim_hit = s_acc.claim_rd && (s_win_id != PIA_NO_IRQ);

  // a completion counts only for an id that is now in service
  wire m_done_ok = m_acc.done_wr && (m_acc.done_id != PIA_NO_IRQ) &&
                   (32'(m_acc.done_id) < NSRC) &&
                   in_service[m_acc.done_id];
  wire s_done_ok = s_acc.done_wr && (s_acc.done_id != PIA_NO_IRQ) &&
                   (32'(s_acc.done_id) < NSRC) &&
                   in_service[s_acc.done_id];

  // per source gateway: one generate loop over all ids
  logic [NSRC-1:0] set_mask;      // gateway fires this cycle
  logic [NSRC-1:0] claim_mask;    // claimed by either context
  logic [NSRC-1:0] done_mask;     // completed by either context
  logic [NSRC-1:0] next_pending;  // next waiting flags
  logic [NSRC-1:0] next_service;  // next in-service flags

  for (genvar i = 0; i < NSRC; i++) begin : g_gw
    if (i == 0) begin : g_zero
      // id zero has no gateway at all
      assign set_mask[i]     = 1'b0;
      assign claim_mask[i]   = 1'b0;
      assign done_mask[i]    = 1'b0;
      assign next_pending[i] = 1'b0;
      assign next_service[i] = 1'b0;
    end else begin : g_src
      // level seen while idle raises the waiting flag; a source still
      // in service is masked so it cannot pend again before completion
      assign set_mask[i]   = src_req[i] && !in_service[i];
      assign claim_mask[i] = (m_claim_hit && m_win_id == PIA_ID_W'(i)) ||
                             (s_claim_hit && s_win_id == PIA_ID_W'(i));
      assign done_mask[i]  = (m_done_ok && m_acc.done_id == PIA_ID_W'(i)) ||
                             (s_done_ok && s_acc.done_id == PIA_ID_W'(i));
      // claim clears waiting; a claimed source is in service so set is off
      assign next_pending[i] = claim_mask[i] ? 1'b0 :
                               (pending[i] | set_mask[i]);
      // claim wins over a same-cycle completion so nothing is lost
      assign next_service[i] = claim_mask[i] ? 1'b1 :
                               (in_service[i] & ~done_mask[i]);
    end
  end

  // gateway state registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pending    <= {NSRC{PIA_RST_BIT}};
      in_service <= {NSRC{PIA_RST_BIT}};
    end else begin
      pending    <= next_pending;
      in_service <= next_service;
    end
  end

  // claim answers, held until the next claim read on the same context
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      m_claim_id <= PIA_NO_IRQ;
      s_claim_id <= PIA_NO_IRQ;
    end else begin
      if (m_acc.claim_rd) begin
        m_claim_id <= m_win_id;
      end
      if (s_acc.claim_rd) begin
        s_claim_id <= s_win_id;
      end
    end
  end

  // request lines registered, one cycle behind the arbitration
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hart_external_request_m <= 1'b0;
      hart_external_request_s <= 1'b0;
    end else begin
      hart_external_request_m <= m_over;
      hart_external_request_s <= s_over;
    end
  end

  // every check below runs on the core clock and sleeps during reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // gateway and context checks; they watch internal state so a fault
  // shows near its cause rather than cycles later at the request line

  zero_quiet_a: assert property (!pending[0] && !in_service[0])
    else $error("id zero became pending or in service");
  gate_set_a: assert property (
    ##1 ((pending | in_service) & $past(set_mask)) == $past(set_mask))
    else $error("asserted source did not pend");
  m_thresh_a: assert property (
    hart_external_request_m == $past(m_win_prio > m_cfg.threshold[PRIO_W-1:0]))
    else $error("machine request disagrees with threshold");
  s_line_a: assert property ((s_win_id == PIA_NO_IRQ) |=>
    !hart_external_request_s)
    else $error("supervisor request with no winner");
  claim_zero_a: assert property (
    (m_acc.claim_rd && m_win_id == PIA_NO_IRQ) |=> m_claim_id == PIA_NO_IRQ)
    else $error("empty claim did not return zero");
  claim_clear_a: assert property (m_claim_hit |=>
    !pending[$past(m_win_id)] && m_claim_id == $past(m_win_id))
    else $error("claim did not clear waiting flag");
  quiet_serv_a: assert property ((pending & in_service) == '0)
    else $error("source pending while in service");
  done_rearm_a: assert property (
    (m_done_ok && !claim_mask[m_acc.done_id]) |=>
    !in_service[$past(m_acc.done_id)])
    else $error("completion did not re-arm gateway");
  bad_done_a: assert property (
    (!m_done_ok && !s_done_ok && claim_mask == '0) |=>
    in_service == $past(in_service))
    else $error("ignored completion changed state");
  win_allow_a: assert property ((m_win_id != PIA_NO_IRQ) |->
    pending[m_win_id] && m_cfg.allow[m_win_id] &&
    src_priority[m_win_id] == m_win_prio)
    else $error("winner not pending, allowed or priority lost");
  // supervisor line follows its own threshold compare one cycle later
  s_thresh_a: assert property (
    hart_external_request_s == $past(s_over))
    else $error("supervisor request disagrees with threshold");
  // supervisor claim moves the winner from waiting into service
  s_clear_a: assert property (s_claim_hit |=>
    !pending[$past(s_win_id)] && in_service[$past(s_win_id)])
    else $error("supervisor claim did not clear waiting flag");

  // no allowed waiting source outranks the machine winner, and one of
  // equal priority may only stand behind it with a larger id
  for (genvar j = 1; j < NSRC; j++) begin : g_rank
    m_rank_a: assert property (
      (pending[j] && m_cfg.allow[j] && m_win_id != PIA_ID_W'(j)) |->
      (src_priority[j] < m_win_prio ||
       (src_priority[j] == m_win_prio && PIA_ID_W'(j) > m_win_id)))
      else $error("machine winner outranked by another source");
  end

  cover_claim_c: cover property (m_claim_hit ##[1:8] m_done_ok);
  cover_both_c: cover property (hart_external_request_m &&
                                hart_external_request_s);
  cover_empty_c: cover property (s_acc.claim_rd && s_win_id == PIA_NO_IRQ);
  cover_race_c: cover property (m_claim_hit && s_claim_hit);
endmodule
`default_nettype wire

/* File: design/pia_pkg.sv */
// shared constants and carrier types of the platform interrupt arbiter
package pia_pkg;
  localparam int unsigned PIA_MAX_SRC  = 32;    // largest source count
  localparam int unsigned PIA_NSRC     = 32;    // default source count
  localparam int unsigned PIA_PRIO_W   = 3;     // default priority width
  localparam int unsigned PIA_ID_W     = 5;     // width of an interrupt id
  localparam logic [4:0]  PIA_NO_IRQ   = 5'h00; // id meaning no interrupt
  localparam logic        PIA_RST_BIT  = 1'b0;  // reset value of flag bits

  // one firmware access port per output context
  typedef struct packed {
    logic                claim_rd;  // claim read strobe, one cycle
    logic                done_wr;   // completion write strobe, one cycle
    logic [PIA_ID_W-1:0] done_id;   // id carried by the completion
  } pia_access_t;

  // per output context configuration
  typedef struct packed {
    logic [PIA_MAX_SRC-1:0] allow;     // source_allow_flag per source
    logic [PIA_PRIO_W-1:0]  threshold; // winning priority must exceed
  } pia_ctx_cfg_t;
endpackage

/* File: design/pia_arbiter.sv */
// linear priority scan for one output context: picks highest enabled pending source
`timescale 1ns/1ps
`default_nettype none
module pia_arbiter
  import pia_pkg::*;
#(
  parameter int unsigned NSRC   = PIA_NSRC,
  parameter int unsigned PRIO_W = PIA_PRIO_W
) (
  input  wire logic [NSRC-1:0]             pending,  // source_waiting_flag
  input  wire logic [NSRC-1:0]             allow,    // source_allow_flag
  input  wire logic [NSRC-1:0][PRIO_W-1:0] prio,     // per source priority
  output logic      [PIA_ID_W-1:0]         win_id,   // winning id, 0 if none
  output logic      [PRIO_W-1:0]           win_prio  // winning priority
);
  // the id field holds 32 ids at most and the scan starts at id one
  if (NSRC > PIA_MAX_SRC || NSRC < 2 || PRIO_W < 1) begin : g_bad
    $error("pia_arbiter: NSRC must be 2..32, PRIO_W at least 1");
  end

  // linear scan from id 1 upward; strict compare keeps the lower id on a
  // tie and lets a priority of zero never win, trading depth for area
  always_comb begin
    win_id   = PIA_NO_IRQ;
    win_prio = '0;
    for (int i = 1; i < NSRC; i++) begin
      if (pending[i] && allow[i] && (prio[i] > win_prio)) begin
        win_prio = prio[i];                    // larger priority kept
        win_id   = PIA_ID_W'(i);               // equal priority: lower id
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/pia_far_model.sv */
// far side model: peripheral sources that hold level requests
`timescale 1ns/1ps
`default_nettype none
module pia_far_model (
  input  wire logic        core_clk, // system clock
  input  wire logic        rstn,     // async reset, active low
  input  wire logic [31:0] raise,    // source starts asking for service
  input  wire logic [31:0] lower,    // source was served, drops request
  output logic      [31:0] src_req   // level requests toward the gateways
);
  // a source keeps its level until served; dropping early would hide
  // a gateway that forgets to mask a source in service
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      src_req <= 32'h0;
    end else begin
      src_req <= (src_req | raise) & ~lower;
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the platform interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pia_pkg::*;
  logic             core_clk = 1'b0;   // 250 MHz clock
  logic             rstn = 1'b0;       // reset, active low
  logic [31:0]      raise = '0;        // commands to the sources
  logic [31:0]      lower = '0;        // service-done commands
  logic [31:0]      src_req;           // source levels
  logic [31:0][2:0] src_priority = '0; // per source priority
  pia_ctx_cfg_t     m_cfg = '0;        // machine context config
  pia_ctx_cfg_t     s_cfg = '0;        // supervisor context config
  pia_access_t      m_acc = '0;        // machine claim port
  pia_access_t      s_acc = '0;        // supervisor claim port
  logic [4:0]       m_claim_id;        // machine claim answer
  logic [4:0]       s_claim_id;        // supervisor claim answer
  logic             m_irq;             // machine request line
  logic             s_irq;             // supervisor request line
  logic [31:0]      waiting;           // pending flags
  logic [31:0]      in_svc;            // claimed, not completed
  int               mismatches = 0;    // failed comparisons
  int               n_compared = 0;    // all comparisons
  int               cycles = 0;        // timeout counter

  pia_far_model far (.core_clk(core_clk), .rstn(rstn), .raise(raise),
    .lower(lower), .src_req(src_req));
  pia_core #(.NSRC(32), .PRIO_W(3)) DUT (.core_clk(core_clk), .rstn(rstn),
    .src_req(src_req), .src_priority(src_priority), .m_cfg(m_cfg),
    .s_cfg(s_cfg), .m_acc(m_acc), .s_acc(s_acc), .m_claim_id(m_claim_id),
    .s_claim_id(s_claim_id), .hart_external_request_m(m_irq),
    .hart_external_request_s(s_irq), .source_waiting_flag(waiting),
    .source_in_service(in_svc));

  // clock and hang guard; the tests need well under a hundred cycles
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s: expected %h, seen %h", w, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // raise one source; three edges cover source, gateway and request flop
  task automatic up(input int id, input logic [2:0] p);
    src_priority[id] = p;
    raise[id] = 1'b1;
    cyc(1);
    raise[id] = 1'b0;
    cyc(3);
  endtask
  // one-cycle claim strobe; the answer lands one edge later, and a
  // quiet edge follows so a second claim never re-raises in one step
  task automatic claim(input logic sup, input logic [4:0] e, input string w);
    if (sup) s_acc.claim_rd = 1'b1;
    else m_acc.claim_rd = 1'b1;
    cyc(1);
    s_acc.claim_rd = 1'b0;
    m_acc.claim_rd = 1'b0;
    chk(w, e, sup ? s_claim_id : m_claim_id);
    cyc(1);
  endtask
  // one-cycle completion strobe on the chosen context
  task automatic done(input logic sup, input logic [4:0] id);
    if (sup) begin
      s_acc.done_wr = 1'b1;
      s_acc.done_id = id;
    end else begin
      m_acc.done_wr = 1'b1;
      m_acc.done_id = id;
    end
    cyc(1);
    s_acc.done_wr = 1'b0;
    m_acc.done_wr = 1'b0;
    cyc(3);
  endtask

  task automatic t_zero();
    m_cfg = '{allow: '1, threshold: 3'h0};
    up(0, 3'h7);
    chk("waiting", 32'h0, waiting);
    chk("m_irq", 32'h0, m_irq);
    claim(1'b0, 5'h00, "empty claim");
    $display("test reserved source done");
  endtask
  task automatic t_thresh();
    m_cfg = '{allow: 32'h0010_0000, threshold: 3'h3};
    s_cfg = '{allow: 32'h0, threshold: 3'h2};
    up(20, 3'h3);
    chk("m_irq at threshold", 32'h0, m_irq);
    chk("waiting", 32'h0010_0000, waiting);
    s_cfg.allow = 32'h0010_0000;
    cyc(3);
    chk("s_irq", 32'h1, s_irq);
    chk("m_irq", 32'h0, m_irq);
    m_cfg.threshold = 3'h2;
    cyc(3);
    chk("m_irq over threshold", 32'h1, m_irq);
    claim(1'b1, 5'h14, "s claim");
    lower[20] = 1'b1;
    cyc(1);
    lower[20] = 1'b0;
    done(1'b1, 5'h14);
    chk("in service", 32'h0, in_svc);
    $display("test threshold done");
  endtask
  task automatic t_arb();
    m_cfg = '{allow: '1, threshold: 3'h0};
    s_cfg = '0;
    up(5, 3'h4);
    up(9, 3'h4);
    claim(1'b0, 5'h05, "tie claim");
    chk("waiting", 32'h0000_0200, waiting);
    chk("in service", 32'h0000_0020, in_svc);
    claim(1'b0, 5'h09, "second claim");
    up(3, 3'h2);
    up(12, 3'h6);
    src_priority[7] = 3'h7;
    claim(1'b0, 5'h0c, "high prio");
    claim(1'b0, 5'h03, "low prio");
    claim(1'b0, 5'h00, "empty after claims");
    $display("test arbitration done");
  endtask
  task automatic t_complete();
    cyc(4);
    chk("held level", 32'h0, waiting);
    done(1'b0, 5'h00);
    done(1'b0, 5'h07);
    chk("in service", 32'h0000_1228, in_svc);
    done(1'b0, 5'h05);
    chk("re-armed", 32'h0000_0020, waiting);
    chk("m_irq", 32'h1, m_irq);
    claim(1'b0, 5'h05, "reclaim");
    $display("test completion done");
  endtask

  initial begin
    cyc(2);
    rstn = 1'b1;
    cyc(1);
    t_zero();
    t_thresh();
    t_arb();
    t_complete();
    tally_and_finish();
  end
endmodule
`default_nettype wire
